/* File: hdl/sdmc_clkdiv.sv */
`timescale 1ns/100ps
`default_nettype none
module sdmc_clkdiv
   import sdmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   sdmc_div_if.div bus
);
   logic [5:0] cnt;
   logic [5:0] limit;

   // Period 2*(ratio+1) cycles, or every cycle in bypass
   assign limit = {bus.ratio, 1'b1};

   always_ff @(posedge clk_i) begin
      if (rst_i || !bus.run) begin
         cnt <= 6'h00;
         bus.tick <= 1'b0;
      end else if (bus.ratio == DIV_BYPASS) begin
         cnt <= 6'h00;
         bus.tick <= 1'b1;
      end else if (cnt == limit) begin
         cnt <= 6'h00;
         bus.tick <= 1'b1;
      end else begin
         cnt <= cnt + 6'h01;
         bus.tick <= 1'b0;
      end
   end

   property p_div_bypass;
      @(posedge clk_i) disable iff (rst_i)
      bus.run && bus.ratio == DIV_BYPASS ##1
      bus.run && bus.ratio == DIV_BYPASS |-> bus.tick;
   endproperty
   a_div_bypass: assert property (p_div_bypass)
      else $error("bypass divider missed a tick");

   property p_div_idle;
      @(posedge clk_i) disable iff (rst_i)
      !bus.run |=> !bus.tick;
   endproperty
   a_div_idle: assert property (p_div_idle)
      else $error("divider ticked while stopped");
endmodule
`default_nettype wire

/* File: hdl/sdmc_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Power-off wins; else sleep; else reset bit picks reset or normal.
// - Power-down, regulator off: every analog block and filter off.
// - Power-down, regulator on: bandgap, regulator, common-mode stay on.
// - Sleep keeps bandgap, common-mode, amplifier, filter; regulator follows its enable; rest off.
// - Normal/reset power converter, amplifier; temp sensor, buffers selected.
// - Reset bit high holds filter reset; its fall starts a conversion.
// - Common-mode source follows the bandgap exactly.
// - End-of-conversion flag set on each completed conversion while latch is off.
// - Each completion with latch off sets request flag; interrupt only when enabled.
// - Latch off: results overwrite the result registers each time.
// - Latch on: results frozen, later results discarded.
// - Converter clock is system clock, direct or divided by field.
// - Reference select picks internal or external reference pair.
// - Data rate set by oversampling and filter clock/chop fields.
// - Result is 24-bit two's complement, sign in top bit.
// - Latch on: conversions continue, no interrupt, flag unchanged.
// - Reset bit aborts conversion; nothing starts until it falls.
// - Result split into low, middle and high read-only bytes.
module sdmc_ctrl
   import sdmc_pkg::*;
#(
   parameter logic [3:0] TEMP_CH = TEMP_CH_DEF
)(
   input wire logic SYS_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [WB_AW-1:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [WB_DW-1:0] DAT_I,
   output logic [WB_DW-1:0] DAT_O,
   output logic ACK_O,
   input wire logic [RES_W-1:0] FILT_DATA_I,
   input wire logic FILT_VALID_I,
   output logic BANDGAP_ON_O,
   output logic REGULATOR_ON_O,
   output logic COMMON_MODE_ON_O,
   output logic AMP_ON_O,
   output logic CONV_ON_O,
   output logic TEMP_SENSOR_ON_O,
   output logic POS_REF_BUF_ON_O,
   output logic NEG_REF_BUF_ON_O,
   output logic FILT_ON_O,
   output logic FILT_RST_O,
   output logic FILT_START_O,
   output logic CONV_CLK_EN_O,
   output logic REF_PAIR_SEL_O,
   output logic [2:0] OSR_SEL_O,
   output logic [2:0] FILT_CLK_CHOP_SEL_O,
   output logic [1:0] MODE_O,
   output logic IRQ_O
);
   logic [7:0] ctrl0;
   logic [7:0] ctrl1;
   logic [4:0] converter_clock_divider;
   logic [7:0] chsel;
   logic regulator_enable;
   logic global_interrupt_enable;
   logic converter_interrupt_enable;
   logic irq_flag;
   logic [RES_W-1:0] result;
   logic started;
   logic frst_q;
   logic [7:0] rd_data;
   logic wr_en;
   logic rd_req;
   logic done;
   logic conv_on;
   logic temp_sel;
   sdmc_mode_t mode;
   sdmc_mode_t next_mode;

   logic filter_reset;
   logic converter_sleep;
   logic converter_power_off;
   logic result_latch_enable;
   logic eoc_flag;
   logic [3:0] pos_channel_select;
   logic [3:0] neg_channel_select;

   assign filter_reset = ctrl0[B_FRST];
   assign converter_sleep = ctrl0[B_SLEEP];
   assign converter_power_off = ctrl0[B_POFF];
   assign result_latch_enable = ctrl1[B_LATCH];
   assign eoc_flag = ctrl1[B_EOC];
   assign pos_channel_select = chsel[B_PCH +: 4];
   assign neg_channel_select = chsel[B_NCH +: 4];

   sdmc_div_if div_bus();

   // Bus access: ack one cycle after request, write on ack edge
   assign wr_en = CYC_I && STB_I && WE_I && ACK_O && SEL_I[0];
   assign rd_req = CYC_I && STB_I && !ACK_O;

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         ACK_O <= 1'b0;
      end else begin
         ACK_O <= rd_req;
      end
   end

   always_comb begin
      rd_data = 8'h00;
      case (ADR_I)
         OFS_CTRL0: begin
            rd_data = ctrl0;
         end
         OFS_CTRL1: begin
            rd_data = ctrl1;
         end
         OFS_CLKDIV: begin
            rd_data = {3'h0, converter_clock_divider};
         end
         OFS_RES_LO: begin
            rd_data = result[7:0];
         end
         OFS_RES_MID: begin
            rd_data = result[15:8];
         end
         OFS_RES_HI: begin
            rd_data = result[23:16];
         end
         OFS_CHSEL: begin
            rd_data = chsel;
         end
         OFS_PWR: begin
            rd_data = {7'h00, regulator_enable};
         end
         OFS_INTC: begin
            rd_data = {5'h00, irq_flag, converter_interrupt_enable,
               global_interrupt_enable};
         end
         default: begin
            rd_data = 8'h00;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         DAT_O <= 32'h0000_0000;
      end else if (rd_req) begin
         DAT_O <= {24'h00_0000, rd_data};
      end
   end

   // Control registers, unused bits read zero
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         ctrl0 <= RST_CTRL0;
      end else if (wr_en && ADR_I == OFS_CTRL0) begin
         ctrl0 <= DAT_I[7:0] & 8'hFD;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         converter_clock_divider <= RST_CLKDIV;
         chsel <= RST_CHSEL;
         regulator_enable <= 1'b0;
         global_interrupt_enable <= 1'b0;
         converter_interrupt_enable <= 1'b0;
      end else if (wr_en) begin
         if (ADR_I == OFS_CLKDIV) begin
            converter_clock_divider <= DAT_I[4:0];
         end
         if (ADR_I == OFS_CHSEL) begin
            chsel <= DAT_I[7:0];
         end
         if (ADR_I == OFS_PWR) begin
            regulator_enable <= DAT_I[B_REGEN];
         end
         if (ADR_I == OFS_INTC) begin
            global_interrupt_enable <= DAT_I[B_GIE];
            converter_interrupt_enable <= DAT_I[B_CIE];
         end
      end
   end

   // Flag bits: hardware set wins over a software clear
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         ctrl1 <= RST_CTRL1;
      end else begin
         if (wr_en && ADR_I == OFS_CTRL1) begin
            ctrl1 <= DAT_I[7:0] & 8'hFE;
         end
         if (done && !result_latch_enable) begin
            ctrl1[B_EOC] <= 1'b1;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         irq_flag <= 1'b0;
      end else if (done && !result_latch_enable) begin
         irq_flag <= 1'b1;
      end else if (wr_en && ADR_I == OFS_INTC) begin
         irq_flag <= DAT_I[B_IRQF];
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= irq_flag && global_interrupt_enable
            && converter_interrupt_enable;
      end
   end

   // Operating mode decode
   always_comb begin
      if (converter_power_off) begin
         next_mode = SDMC_PDN;
      end else if (converter_sleep) begin
         next_mode = SDMC_SLP;
      end else if (filter_reset) begin
         next_mode = SDMC_RST;
      end else begin
         next_mode = SDMC_NORM;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         mode <= SDMC_PDN;
      end else begin
         mode <= next_mode;
      end
   end

   assign conv_on = !converter_power_off && !converter_sleep;
   assign temp_sel = pos_channel_select == TEMP_CH
      || neg_channel_select == TEMP_CH;

   // Power switches, all from the same register edge as mode
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         BANDGAP_ON_O <= 1'b0;
         COMMON_MODE_ON_O <= 1'b0;
         REGULATOR_ON_O <= 1'b0;
         AMP_ON_O <= 1'b0;
         FILT_ON_O <= 1'b0;
      end else begin
         BANDGAP_ON_O <= !converter_power_off
            || regulator_enable;
         COMMON_MODE_ON_O <= !converter_power_off
            || regulator_enable;
         REGULATOR_ON_O <= regulator_enable;
         AMP_ON_O <= !converter_power_off;
         FILT_ON_O <= !converter_power_off;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         CONV_ON_O <= 1'b0;
         TEMP_SENSOR_ON_O <= 1'b0;
         POS_REF_BUF_ON_O <= 1'b0;
         NEG_REF_BUF_ON_O <= 1'b0;
      end else begin
         CONV_ON_O <= conv_on;
         TEMP_SENSOR_ON_O <= conv_on && temp_sel;
         POS_REF_BUF_ON_O <= conv_on && ctrl1[B_PBUF];
         NEG_REF_BUF_ON_O <= conv_on && ctrl1[B_NBUF];
      end
   end

   // Rate and reference selections
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         REF_PAIR_SEL_O <= 1'b0;
         OSR_SEL_O <= 3'h0;
         FILT_CLK_CHOP_SEL_O <= 3'h0;
         MODE_O <= SDMC_PDN;
      end else begin
         REF_PAIR_SEL_O <= ctrl0[B_REFSEL];
         OSR_SEL_O <= ctrl0[B_OSR +: 3];
         FILT_CLK_CHOP_SEL_O <= ctrl1[B_FLMS +: 3];
         MODE_O <= next_mode;
      end
   end

   // Converter clock enable from the divider
   assign div_bus.ratio = converter_clock_divider;
   assign div_bus.run = conv_on;

   sdmc_clkdiv u_div (
      .clk_i(SYS_CLK_I),
      .rst_i(SYS_RST_I),
      .bus(div_bus.div)
   );

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         CONV_CLK_EN_O <= 1'b0;
      end else begin
         CONV_CLK_EN_O <= div_bus.tick;
      end
   end

   // Filter reset and conversion start
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         frst_q <= 1'b0;
         FILT_RST_O <= 1'b0;
         FILT_START_O <= 1'b0;
      end else begin
         frst_q <= filter_reset;
         FILT_RST_O <= filter_reset;
         FILT_START_O <= frst_q && !filter_reset && conv_on;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         started <= 1'b0;
      end else if (filter_reset || !conv_on) begin
         started <= 1'b0;
      end else if (FILT_START_O) begin
         started <= 1'b1;
      end
   end

   assign done = FILT_VALID_I && started
      && mode == SDMC_NORM && !filter_reset;

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         result <= '0;
      end else if (done && !result_latch_enable) begin
         result <= FILT_DATA_I;
      end
   end

   property p_mode_pdn;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      converter_power_off |=> mode == SDMC_PDN && !AMP_ON_O;
   endproperty
   a_mode_pdn: assert property (p_mode_pdn)
      else $error("power-off did not force power-down");

   property p_pdn_all_off;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      mode == SDMC_PDN && !REGULATOR_ON_O |-> !BANDGAP_ON_O
         && !COMMON_MODE_ON_O && !CONV_ON_O && !FILT_ON_O
         && !TEMP_SENSOR_ON_O && !POS_REF_BUF_ON_O;
   endproperty
   a_pdn_all_off: assert property (p_pdn_all_off)
      else $error("block left on in power-down");

   property p_pdn_reg_on;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      mode == SDMC_PDN && REGULATOR_ON_O |-> BANDGAP_ON_O
         && !AMP_ON_O && !NEG_REF_BUF_ON_O;
   endproperty
   a_pdn_reg_on: assert property (p_pdn_reg_on)
      else $error("power-down with regulator wrong");

   property p_sleep;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      mode == SDMC_SLP |-> BANDGAP_ON_O && AMP_ON_O && FILT_ON_O
         && !CONV_ON_O && !TEMP_SENSOR_ON_O && !POS_REF_BUF_ON_O;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep power set wrong");

   property p_run_power;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (mode == SDMC_NORM || mode == SDMC_RST) |-> CONV_ON_O
         && AMP_ON_O && POS_REF_BUF_ON_O == $past(ctrl1[B_PBUF]);
   endproperty
   a_run_power: assert property (p_run_power)
      else $error("normal mode power set wrong");

   property p_start;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      $fell(filter_reset) && conv_on |=> FILT_START_O ##1 !FILT_START_O;
   endproperty
   a_start: assert property (p_start)
      else $error("reset release gave no single start");

   property p_vcm;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      COMMON_MODE_ON_O == BANDGAP_ON_O;
   endproperty
   a_vcm: assert property (p_vcm)
      else $error("common-mode differs from bandgap");

   property p_eoc_set;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      done && !result_latch_enable |=> eoc_flag && irq_flag;
   endproperty
   a_eoc_set: assert property (p_eoc_set)
      else $error("completion did not set flags");

   property p_irq;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      IRQ_O |-> $past(irq_flag && global_interrupt_enable
         && converter_interrupt_enable);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt without enabled request");

   property p_update;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      done && !result_latch_enable |=> result == $past(FILT_DATA_I);
   endproperty
   a_update: assert property (p_update)
      else $error("result not overwritten");

   property p_latch;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      result_latch_enable ##1 result_latch_enable |-> $stable(result)
         && !$rose(irq_flag);
   endproperty
   a_latch: assert property (p_latch)
      else $error("latched result or request changed");

   property p_abort;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      filter_reset |=> !$rose(eoc_flag) && !started;
   endproperty
   a_abort: assert property (p_abort)
      else $error("conversion completed under reset");
endmodule
`default_nettype wire

/* File: hdl/sdmc_div_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface sdmc_div_if;
   logic [4:0] ratio;
   logic run;
   logic tick;
   modport ctl(output ratio, output run, input tick);
   modport div(input ratio, input run, output tick);
endinterface
`default_nettype wire

/* File: hdl/sdmc_pkg.sv */
package sdmc_pkg;
   localparam int unsigned WB_AW = 8;
   localparam int unsigned WB_DW = 32;
   localparam int unsigned RES_W = 24;

   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_CLKDIV = 8'h08;
   localparam logic [7:0] OFS_RES_LO = 8'h0C;
   localparam logic [7:0] OFS_RES_MID = 8'h10;
   localparam logic [7:0] OFS_RES_HI = 8'h14;
   localparam logic [7:0] OFS_CHSEL = 8'h18;
   localparam logic [7:0] OFS_PWR = 8'h1C;
   localparam logic [7:0] OFS_INTC = 8'h20;

   localparam int unsigned B_FRST = 7;
   localparam int unsigned B_SLEEP = 6;
   localparam int unsigned B_POFF = 5;
   localparam int unsigned B_OSR = 2;
   localparam int unsigned B_REFSEL = 0;
   localparam int unsigned B_FLMS = 5;
   localparam int unsigned B_NBUF = 4;
   localparam int unsigned B_PBUF = 3;
   localparam int unsigned B_LATCH = 2;
   localparam int unsigned B_EOC = 1;
   localparam int unsigned B_PCH = 4;
   localparam int unsigned B_NCH = 0;
   localparam int unsigned B_REGEN = 0;
   localparam int unsigned B_GIE = 0;
   localparam int unsigned B_CIE = 1;
   localparam int unsigned B_IRQF = 2;

   localparam logic [7:0] RST_CTRL0 = 8'h20;
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [4:0] RST_CLKDIV = 5'h00;
   localparam logic [7:0] RST_CHSEL = 8'h00;
   localparam logic [4:0] DIV_BYPASS = 5'h1F;
   localparam logic [3:0] TEMP_CH_DEF = 4'hF;

   typedef enum logic [1:0] {
      SDMC_PDN = 2'b00,
      SDMC_NORM = 2'b01,
      SDMC_RST = 2'b11,
      SDMC_SLP = 2'b10
   } sdmc_mode_t;
endpackage

/* File: tb/sdmc_ctrl_test.sv */
`timescale 1ns/100ps
`default_nettype none
module sdmc_ctrl_test
   import sdmc_pkg::*;
;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic cyc = 1'h0;
   logic stb = 1'h0;
   logic we = 1'h0;
   logic rogue = 1'h0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [3:0] bsel = 4'hF;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] dat_o;
   logic ack, bg, rg, cm, amp, conv, tmp, pb, nb, fon, frst, fst, cken;
   logic refs, irq, fvalid;
   logic [2:0] osr, fcc;
   logic [1:0] mode;
   logic [23:0] fdata, last, res, old;
   logic [8:0] pw;
   int seed = 35341;
   int num_errors = 0;
   int total_checks = 0;
   assign pw = {bg, rg, cm, amp, conv, tmp, pb, nb, fon};
   always #2 clk = ~clk;

   sdmc_ctrl sdmc_ctrl_i (
      .SYS_CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb),
      .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o),
      .ACK_O(ack), .FILT_DATA_I(fdata), .FILT_VALID_I(fvalid),
      .BANDGAP_ON_O(bg), .REGULATOR_ON_O(rg), .COMMON_MODE_ON_O(cm),
      .AMP_ON_O(amp), .CONV_ON_O(conv), .TEMP_SENSOR_ON_O(tmp),
      .POS_REF_BUF_ON_O(pb), .NEG_REF_BUF_ON_O(nb), .FILT_ON_O(fon),
      .FILT_RST_O(frst), .FILT_START_O(fst), .CONV_CLK_EN_O(cken),
      .REF_PAIR_SEL_O(refs), .OSR_SEL_O(osr),
      .FILT_CLK_CHOP_SEL_O(fcc), .MODE_O(mode), .IRQ_O(irq)
   );

   sdmc_filt_model sdmc_filt_model_i (
      .clk_i(clk), .frst_i(frst), .on_i(fon), .start_i(fst),
      .rogue_i(rogue), .valid_o(fvalid), .data_o(fdata), .last_o(last)
   );

   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic fail(input string m);
      num_errors++;
      $display("BAD %0t %s", $time, m);
      stop_test();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string m);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Bus cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] r);
      int i;
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      sel <= bsel;
      wdat <= {24'h000000, d};
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (ack === 1'h1) break;
      end
      if (i == 20) fail("bus timeout");
      r = dat_o[7:0];
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      wb(1'h1, a, d, r);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      wb(1'h0, a, 8'h00, r);
   endtask

   task automatic rres(output logic [23:0] v);
      rd(OFS_RES_LO, v[7:0]);
      rd(OFS_RES_MID, v[15:8]);
      rd(OFS_RES_HI, v[23:16]);
   endtask

   task automatic wvalid(input int n);
      int k;
      k = 0;
      while (n > 0) begin
         @(posedge clk);
         if (fvalid === 1'h1) n--;
         k++;
         if (k > 5000) fail("no result");
      end
      tk(3);
   endtask

   task automatic weoc;
      logic [7:0] r;
      int k;
      for (k = 0; k < 1000; k++) begin
         rd(OFS_CTRL1, r);
         if (r[B_EOC] === 1'h1) break;
      end
      if (k == 1000) fail("no eoc");
   endtask

   task automatic gap(output int n);
      int k;
      for (k = 0; k < 100 && cken !== 1'h1; k++) @(posedge clk);
      for (n = 1; n < 100; n++) begin
         @(posedge clk);
         if (cken === 1'h1) break;
      end
   endtask

   function automatic logic [8:0] pexp(input logic g, p, s, t, bp, bn);
      if (p) return {g, g, g, 6'h00};
      if (s) return {1'h1, g, 2'h3, 4'h0, 1'h1};
      return {1'h1, g, 2'h3, 1'h1, t, bp, bn, 1'h1};
   endfunction

   function automatic logic [1:0] mexp(input logic p, s, r);
      return p ? SDMC_PDN : s ? SDMC_SLP : r ? SDMC_RST : SDMC_NORM;
   endfunction

   initial begin
      int i, k, n;
      logic [31:0] v;
      logic [7:0] rb, c0;
      logic g, p, s, r;
      logic [8:0] m;
      logic [4:0] dv;
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      chk(mode, SDMC_PDN, "reset mode");
      chk(pw, 9'h000, "reset power");
      bsel = 4'hE;
      wr(OFS_CLKDIV, 8'h05);
      bsel = 4'hF;
      wr(8'h40, 8'hFF);
      rd(OFS_CTRL0, rb);
      chk(rb, RST_CTRL0, "ctrl0 reset");
      rd(OFS_CTRL1, rb);
      chk(rb, RST_CTRL1, "ctrl1 reset");
      rd(OFS_CLKDIV, rb);
      chk(rb, {3'h0, RST_CLKDIV}, "divider reset");
      rd(8'h40, rb);
      chk(rb, 8'h00, "unmapped");
      for (i = 0; i < 16; i++) begin
         v = $random(seed);
         {g, p, s, r} = i[3:0];
         c0 = {r, s, p, v[5:3], 1'h0, v[9]};
         wr(OFS_CTRL0, c0);
         wr(OFS_CTRL1, {v[8:6], v[2:1], 3'h0});
         wr(OFS_PWR, {7'h00, g});
         wr(OFS_CHSEL, v[0] ? 8'hFF : 8'h12);
         tk(2);
         m = (!p && !s && r) ? 9'h1FE : 9'h1FF;
         chk(pw & m, pexp(g, p, s, v[0], v[1], v[2]) & m, "power");
         chk(mode, mexp(p, s, r), "mode");
         chk(frst, r, "filter reset");
         chk({refs, osr, fcc}, {v[9], v[5:3], v[8:6]}, "selects");
         rd(OFS_CTRL0, rb);
         chk(rb, c0, "ctrl0 readback");
      end
      wr(OFS_PWR, 8'h01);
      wr(OFS_CHSEL, 8'h00);
      wr(OFS_CTRL1, 8'h00);
      wr(OFS_CTRL0, 8'h84);
      wr(OFS_CTRL0, 8'h04);
      tk(4);
      rogue <= 1'h1;
      wr(OFS_CTRL0, 8'h84);
      wr(OFS_CTRL1, 8'h00);
      tk(2);
      chk(frst, 1'h1, "reset held");
      wvalid(1);
      rd(OFS_CTRL1, rb);
      chk(rb, 8'h00, "result in reset");
      rres(res);
      chk(res, 24'h000000, "result kept in reset");
      rogue <= 1'h0;
      wr(OFS_INTC, 8'h03);
      wr(OFS_CTRL0, 8'h04);
      for (k = 0; k < 10 && fst !== 1'h1; k++) @(posedge clk);
      chk(fst, 1'h1, "start pulse");
      weoc();
      tk(1);
      chk(irq, 1'h1, "irq raised");
      rres(res);
      chk(res, last, "result max");
      wr(OFS_INTC, 8'h02);
      wr(OFS_CTRL1, 8'h00);
      chk(irq, 1'h0, "irq cleared");
      weoc();
      rd(OFS_INTC, rb);
      chk({irq, rb[B_IRQF]}, 2'h1, "irq masked");
      rres(res);
      chk(res, last, "result min");
      wr(OFS_INTC, 8'h03);
      wr(OFS_CTRL1, 8'h04);
      old = res;
      wr(OFS_RES_LO, ~old[7:0]);
      wvalid(2);
      rd(OFS_CTRL1, rb);
      chk({irq, rb}, 9'h004, "latched flags");
      rres(res);
      chk(res, old, "latched data");
      wr(OFS_CTRL1, 8'h00);
      weoc();
      wvalid(1);
      rres(res);
      chk(res, last, "overwrite");
      rd(OFS_CTRL1, rb);
      chk(rb[B_EOC], 1'h1, "flag kept");
      for (i = 0; i < 4; i++) begin
         v = $random(seed);
         dv = (i == 0) ? 5'h1F : (i == 1) ? 5'h00 : v[4:0];
         if (i == 3) dv = 5'h1E;
         wr(OFS_CLKDIV, {3'h0, dv});
         tk(70);
         gap(n);
         chk(n, (dv == 5'h1F) ? 1 : 2 * (dv + 1), "divider");
      end
      stop_test();
   end
endmodule
`default_nettype wire

/* File: tb/sdmc_filt_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sdmc_filt_model
   import sdmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic frst_i,
   input wire logic on_i,
   input wire logic start_i,
   input wire logic rogue_i,
   output logic valid_o,
   output logic [RES_W-1:0] data_o,
   output logic [RES_W-1:0] last_o
);
   int seed = 35341;
   int cnt = 0;
   int nres = 0;
   logic run = 1'h0;
   logic [RES_W-1:0] d;
   initial begin
      valid_o = 1'h0;
      data_o = 24'h000000;
      last_o = 24'h000000;
   end
   // Extremes first, then random results
   always @(posedge clk_i) begin
      valid_o <= 1'h0;
      data_o <= ~data_o;
      if (start_i) begin
         run <= 1'h1;
         nres <= 0;
         cnt <= 150;
      end else if (!rogue_i && (!on_i || frst_i)) begin
         run <= 1'h0;
      end else if (run && cnt > 0) begin
         cnt <= cnt - 1;
      end else if (run) begin
         d = RES_W'($random(seed));
         if (nres < 2) begin
            d = (nres == 0) ? 24'h7FFFFF : 24'h800000;
         end
         valid_o <= 1'h1;
         data_o <= d;
         last_o <= d;
         nres <= nres + 1;
         cnt <= 150 + ($random(seed) & 63);
      end
   end
endmodule
`default_nettype wire
